// >>> rtl/asfn_pkg.sv
// Shared constants and carrier types for the audio bus superframe node
package asfn_pkg;
  localparam int unsigned CLK_HZ     = 125000000;
  localparam int unsigned SF_RATE_HZ = 48000;
  localparam int unsigned FRAME_BITS = 1024;
  localparam int unsigned CNT_W      = 10;
  // Bit enable from a phase accumulator: FRAME_BITS * SF_RATE_HZ / CLK_HZ per clock
  localparam int unsigned ACC_W      = 16;
  localparam longint     ACC_ONE    = 64'h0000_0000_0001_0000;
  localparam logic [15:0] BIT_STEP  =
    16'((longint'(FRAME_BITS) * longint'(SF_RATE_HZ) * ACC_ONE + longint'(CLK_HZ / 2)) / longint'(CLK_HZ));

  // Superframe layout, in bit times from the start of the preamble
  localparam int unsigned PRE_BITS   = 8;
  localparam logic [7:0]  PREAMBLE   = 8'hB2;
  localparam int unsigned CW_BITS    = 24;
  localparam int unsigned CF_BITS    = PRE_BITS + CW_BITS;
  localparam int unsigned SLOT_BITS  = 16;
  localparam int unsigned SLOTS      = 8;
  localparam int unsigned DN_START   = CF_BITS;
  localparam int unsigned DN_END     = DN_START + SLOTS * SLOT_BITS;
  localparam int unsigned RESP_START = 512;
  localparam int unsigned RW_BITS    = 16;
  localparam int unsigned RF_BITS    = PRE_BITS + RW_BITS;
  localparam int unsigned UP_START   = RESP_START + RF_BITS;
  localparam int unsigned UP_END     = UP_START + SLOTS * SLOT_BITS;

  // Control port
  localparam logic [3:0] ADDR_HI     = 4'h6;
  localparam int unsigned REG_NUM    = 16;
  localparam logic [3:0] REG_RX_SLOT = 4'h0;
  localparam logic [3:0] REG_TX_SLOT = 4'h1;
  localparam logic [3:0] REG_SYNC_DLY = 4'h2;
  localparam logic [3:0] REG_STATUS  = 4'h3;
  localparam logic [7:0] REG_RESET   = 8'h00;

  typedef enum logic [2:0] {PH_CTRL, PH_DN, PH_GAP_DN, PH_RESP, PH_UP, PH_GAP_UP} asfn_phase_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK} asfn_i2c_t;

  typedef struct packed {
    logic [3:0] node;
    logic       wr;
    logic [2:0] pad;
    logic [7:0] reg_addr;
    logic [7:0] data;
  } asfn_ctrl_t;

  typedef struct packed {
    logic [3:0] node;
    logic [3:0] pad;
    logic [7:0] data;
  } asfn_resp_t;
endpackage

// >>> rtl/asfn_node.sv
// Superframe node: timing, slot sequencing, audio hand-over and control port target
`timescale 1ns/1ps
`default_nettype none

module asfn_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Operation
// - Main node generates clock, sync and framing for all subordinates.
// - Superframes run at the sync rate; bus bits at 1024 times it.
// - Superframe holds downstream period, upstream period and undriven period.
// - At most 32 equal-width slots per direction per superframe.
// - Main sends preamble then control data as the sync control frame.
// - Downstream slots follow control frame; subordinates take and add slots; here subordinates only take and forward them downstream.
// - Last subordinate answers each control frame with a sync response frame.
// - Upstream slots follow the response frame; nodes consume and contribute.
// - Control and response frames carry node addressing for remote access.
// - All nodes sample in the same superframe in both directions.
// - Sync output has a register-programmable fine delay.
// - Port samples go on the bus next superframe, and vice versa.
// - Port-to-port audio between nodes takes two frames plus delays.
// - Control port is target-only on main; subordinate supports several initiators.
// - Control port runs at 100 kbps or 400 kbps.
// - Seven-bit addressing, single and burst transfers, clock stretching.
// - Local address from two strap pins latched at reset; four devices.
// - Subordinate answers only its local device address.
// - Main also answers the remote-access address.
// - Address bit 0 clear selects local register access.
// - Address bit 0 set makes main forward the transfer over the bus.
module asfn_node #(
  parameter int unsigned SAMPLE_W  = asfn_pkg::SLOT_BITS,
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                is_main,
  input  wire logic                last_node,
  input  wire logic [3:0]          node_id,
  input  wire logic                address_strap_low,
  input  wire logic                address_strap_high,
  input  wire logic                sync_in,
  output logic                     sync_out,
  input  wire logic                aud_in_valid,
  output logic                     aud_in_ready,
  input  wire logic [SAMPLE_W-1:0] aud_in_data,
  output logic                     aud_out_valid,
  output logic [SAMPLE_W-1:0]      aud_out_data,
  input  wire logic                a_rx,
  output logic                     a_tx,
  output logic                     a_oe,
  input  wire logic                b_rx,
  output logic                     b_tx,
  output logic                     b_oe,
  input  wire logic                scl_in,
  output logic                     scl_oe,
  input  wire logic                sda_in,
  output logic                     sda_oe
);
  localparam int unsigned CW = asfn_pkg::CNT_W;

  function automatic logic [CW-1:0] slot_off(input logic [CW-1:0] cnt, input int unsigned start);
    slot_off = cnt - CW'(start);
  endfunction

  // Bit timing
  logic [15:0]   acc_q;
  logic [16:0]   acc_sum;
  logic          bit_en;
  logic [CW-1:0] bit_cnt_q;
  logic          locked_q;
  logic          sync_q;
  logic          sync_rise;
  logic [7:0]    pre_sr_q;
  logic          pre_hit;
  logic          frame_tick;
  asfn_pkg::asfn_phase_t phase;

  assign acc_sum   = {1'b0, acc_q} + {1'b0, asfn_pkg::BIT_STEP};
  assign bit_en    = acc_sum[16];
  assign sync_rise = sync_in && !sync_q;
  assign pre_hit   = !is_main && bit_en && ({pre_sr_q[6:0], a_rx} == asfn_pkg::PREAMBLE) &&
                     (!locked_q || bit_cnt_q == CW'(asfn_pkg::PRE_BITS - 1));
  assign frame_tick = is_main ? sync_rise : pre_hit;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_q     <= '0;
      bit_cnt_q <= '0;
      locked_q  <= 1'b0;
      sync_q    <= 1'b0;
      pre_sr_q  <= '0;
    end else begin
      sync_q <= sync_in;
      if (bit_en) begin
        pre_sr_q <= {pre_sr_q[6:0], a_rx};
      end
      if (is_main && sync_rise) begin
        // Main restarts the superframe on every host sync rising edge
        acc_q     <= '0;
        bit_cnt_q <= '0;
        locked_q  <= 1'b1;
      end else if (pre_hit) begin
        acc_q     <= acc_sum[15:0];
        bit_cnt_q <= CW'(asfn_pkg::PRE_BITS);
        locked_q  <= 1'b1;
      end else begin
        acc_q <= acc_sum[15:0];
        if (bit_en) begin
          bit_cnt_q <= (bit_cnt_q == CW'(asfn_pkg::FRAME_BITS - 1)) ? '0 : bit_cnt_q + 1'b1;
        end
      end
    end
  end

  always_comb begin
    if (bit_cnt_q < CW'(asfn_pkg::CF_BITS)) begin
      phase = asfn_pkg::PH_CTRL;
    end else if (bit_cnt_q < CW'(asfn_pkg::DN_END)) begin
      phase = asfn_pkg::PH_DN;
    end else if (bit_cnt_q < CW'(asfn_pkg::RESP_START)) begin
      phase = asfn_pkg::PH_GAP_DN;
    end else if (bit_cnt_q < CW'(asfn_pkg::UP_START)) begin
      phase = asfn_pkg::PH_RESP;
    end else if (bit_cnt_q < CW'(asfn_pkg::UP_END)) begin
      phase = asfn_pkg::PH_UP;
    end else begin
      phase = asfn_pkg::PH_GAP_UP;
    end
  end

  // Registers and control port shared state
  logic [7:0]  regs_q [asfn_pkg::REG_NUM];
  logic [6:0]  local_addr_q;
  logic        strap_done_q;
  logic [7:0]  rem_node_q;
  logic [7:0]  rem_reg_q;
  logic [7:0]  rem_data_q;
  logic        rem_pend_q;
  logic [7:0]  rem_rdata_q;
  asfn_pkg::asfn_ctrl_t cf_word_q;
  asfn_pkg::asfn_ctrl_t cw_rx;
  logic [asfn_pkg::CW_BITS-1:0] cw_sr_q;
  logic [7:0]  last_reg_q;

  // Audio path
  logic                out_valid_f;
  logic [SAMPLE_W-1:0] out_data_f;
  logic [SAMPLE_W-1:0] tx_word_q;
  logic [SAMPLE_W-1:0] rx_sr_q;
  logic [SAMPLE_W-1:0] rx_hold_q;
  logic [CW-1:0]       dn_off;
  logic [CW-1:0]       up_off;
  logic [3:0]          bit_pos;
  logic [CW-1:0]       slot_idx;
  logic                rx_win;
  logic                rx_bit;
  logic                tx_own;

  asfn_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_in_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (aud_in_valid),
    .in_ready  (aud_in_ready),
    .in_data   (aud_in_data),
    .out_valid (out_valid_f),
    .out_ready (frame_tick),
    .out_data  (out_data_f)
  );

  assign dn_off   = slot_off(bit_cnt_q, asfn_pkg::DN_START);
  assign up_off   = slot_off(bit_cnt_q, asfn_pkg::UP_START);
  assign rx_win   = is_main ? (phase == asfn_pkg::PH_UP) : (phase == asfn_pkg::PH_DN);
  assign rx_bit   = is_main ? b_rx : a_rx;
  assign slot_idx = (phase == asfn_pkg::PH_UP ? up_off : dn_off) / CW'(asfn_pkg::SLOT_BITS);
  assign bit_pos  = 4'((phase == asfn_pkg::PH_UP ? up_off : dn_off) % CW'(asfn_pkg::SLOT_BITS));
  assign tx_own   = (slot_idx == CW'(regs_q[asfn_pkg::REG_TX_SLOT]));
  assign cw_rx    = cw_sr_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_word_q     <= '0;
      rx_sr_q       <= '0;
      rx_hold_q     <= '0;
      aud_out_valid <= 1'b0;
      aud_out_data  <= '0;
    end else begin
      aud_out_valid <= frame_tick;
      if (frame_tick) begin
        // Sample taken last superframe goes out now; a starved port sends zeros
        tx_word_q    <= out_valid_f ? out_data_f : '0;
        aud_out_data <= rx_hold_q;
      end
      if (bit_en && rx_win) begin
        rx_sr_q <= {rx_sr_q[SAMPLE_W-2:0], rx_bit};
        if (bit_pos == 4'(asfn_pkg::SLOT_BITS - 1) && slot_idx == CW'(regs_q[asfn_pkg::REG_RX_SLOT])) begin
          rx_hold_q <= {rx_sr_q[SAMPLE_W-2:0], rx_bit};
        end
      end
    end
  end

  // Line transmit, one bit per bit enable; undriven in gap periods
  logic [CW-1:0] cf_pos;
  logic [CW-1:0] rf_pos;
  logic [asfn_pkg::CF_BITS-1:0] cf_bits;
  asfn_pkg::asfn_resp_t resp_w;
  logic [asfn_pkg::RF_BITS-1:0] rf_bits;

  assign cf_pos  = CW'(asfn_pkg::CF_BITS - 1) - bit_cnt_q;
  assign cf_bits = {asfn_pkg::PREAMBLE, cf_word_q};
  assign rf_pos  = CW'(asfn_pkg::UP_START - 1) - bit_cnt_q;
  assign resp_w  = '{node: node_id, pad: 4'h0, data: regs_q[last_reg_q[3:0]]};
  assign rf_bits = {asfn_pkg::PREAMBLE, resp_w};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      b_tx <= 1'b0;
      b_oe <= 1'b0;
      a_tx <= 1'b0;
      a_oe <= 1'b0;
    end else if (bit_en) begin
      if (is_main) begin
        b_oe <= locked_q && (phase == asfn_pkg::PH_CTRL || phase == asfn_pkg::PH_DN);
        if (phase == asfn_pkg::PH_CTRL) begin
          b_tx <= cf_bits[cf_pos[4:0]];
        end else begin
          b_tx <= (phase == asfn_pkg::PH_DN) && tx_own && tx_word_q[4'(SAMPLE_W - 1) - bit_pos];
        end
        a_oe <= 1'b0;
        a_tx <= 1'b0;
      end else begin
        // Forwarding adds one bit time per hop
        b_oe <= locked_q && !last_node && (phase == asfn_pkg::PH_CTRL || phase == asfn_pkg::PH_DN);
        b_tx <= a_rx;
        a_oe <= locked_q && (phase == asfn_pkg::PH_RESP || phase == asfn_pkg::PH_UP);
        if (phase == asfn_pkg::PH_RESP) begin
          a_tx <= last_node ? rf_bits[rf_pos[4:0]] : b_rx;
        end else if (phase == asfn_pkg::PH_UP && tx_own) begin
          a_tx <= tx_word_q[4'(SAMPLE_W - 1) - bit_pos];
        end else begin
          a_tx <= !last_node && b_rx;
        end
      end
    end
  end

  // Control frame capture on subordinate, response capture on main
  logic [asfn_pkg::RW_BITS-1:0] rw_sr_q;
  logic cw_apply;

  assign cw_apply = !is_main && bit_en && bit_cnt_q == CW'(asfn_pkg::CF_BITS - 1) &&
                    cw_rx.wr && cw_rx.node == node_id;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cw_sr_q     <= '0;
      rw_sr_q     <= '0;
      last_reg_q  <= '0;
      rem_rdata_q <= '0;
    end else if (bit_en) begin
      if (!is_main && phase == asfn_pkg::PH_CTRL && bit_cnt_q >= CW'(asfn_pkg::PRE_BITS)) begin
        cw_sr_q <= {cw_sr_q[asfn_pkg::CW_BITS-2:0], a_rx};
      end
      if (!is_main && bit_cnt_q == CW'(asfn_pkg::CF_BITS) && cw_rx.node == node_id) begin
        last_reg_q <= cw_rx.reg_addr;
      end
      if (is_main && phase == asfn_pkg::PH_RESP) begin
        rw_sr_q <= {rw_sr_q[asfn_pkg::RW_BITS-2:0], b_rx};
        if (bit_cnt_q == CW'(asfn_pkg::UP_START - 1)) begin
          rem_rdata_q <= {rw_sr_q[6:0], b_rx};
        end
      end
    end
  end

  // Sync output with fine delay in clock cycles
  logic [7:0] dly_q;
  logic       dly_run_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dly_q     <= '0;
      dly_run_q <= 1'b0;
      sync_out  <= 1'b0;
    end else begin
      sync_out <= 1'b0;
      if (!is_main && frame_tick) begin
        dly_q     <= regs_q[asfn_pkg::REG_SYNC_DLY];
        dly_run_q <= 1'b1;
      end else if (dly_run_q) begin
        if (dly_q == '0) begin
          sync_out  <= 1'b1;
          dly_run_q <= 1'b0;
        end else begin
          dly_q <= dly_q - 1'b1;
        end
      end
    end
  end

  // Control port target; inputs are sampled directly, so SCL edges at either rate are seen
  asfn_pkg::asfn_i2c_t st_q;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] sh_q;
  logic [3:0] bitc_q;
  logic       rw_q;
  logic       remote_q;
  logic       nack_q;
  logic [1:0] bidx_q;
  logic [3:0] ptr_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       byte_wr;
  logic [7:0] rd_byte;
  logic [7:0] status;

  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign start_c  = scl_in && scl_q && sda_q && !sda_in;
  assign stop_c   = scl_in && scl_q && !sda_q && sda_in;
  assign byte_wr  = scl_fall && st_q == asfn_pkg::ST_WR && bitc_q == 4'h8;
  assign status   = {5'h00, locked_q, is_main, last_node};
  assign rd_byte  = remote_q ? rem_rdata_q : (ptr_q == asfn_pkg::REG_STATUS ? status : regs_q[ptr_q]);
  // Hold SCL low while a forwarded write waits for its control frame
  assign scl_oe   = remote_q && rem_pend_q && !scl_in && st_q == asfn_pkg::ST_WR;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      local_addr_q <= '0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      local_addr_q <= {asfn_pkg::ADDR_HI, address_strap_high, address_strap_low, 1'b0};
      strap_done_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q     <= asfn_pkg::ST_IDLE;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      sh_q     <= '0;
      bitc_q   <= '0;
      rw_q     <= 1'b0;
      remote_q <= 1'b0;
      nack_q   <= 1'b0;
      sda_oe   <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (start_c) begin
        // Repeated start accepted anywhere; another initiator may take over
        st_q   <= asfn_pkg::ST_ADDR;
        bitc_q <= '0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        st_q   <= asfn_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_q)
          asfn_pkg::ST_ADDR, asfn_pkg::ST_WR: begin
            if (scl_rise) begin
              sh_q   <= {sh_q[6:0], sda_in};
              bitc_q <= bitc_q + 1'b1;
            end else if (scl_fall && bitc_q == 4'h8 && st_q == asfn_pkg::ST_ADDR) begin
              rw_q     <= sh_q[0];
              remote_q <= sh_q[1];
              if (sh_q[7:1] == local_addr_q ||
                  (is_main && sh_q[7:1] == (local_addr_q | 7'h01))) begin
                st_q   <= asfn_pkg::ST_AACK;
                sda_oe <= 1'b1;
              end else begin
                st_q <= asfn_pkg::ST_IDLE;
              end
            end else if (byte_wr) begin
              st_q   <= asfn_pkg::ST_WACK;
              sda_oe <= 1'b1;
            end
          end
          asfn_pkg::ST_AACK, asfn_pkg::ST_WACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                st_q   <= asfn_pkg::ST_RD;
                sh_q   <= {rd_byte[6:0], 1'b0};
                sda_oe <= !rd_byte[7];
                bitc_q <= 4'h1;
              end else begin
                st_q   <= asfn_pkg::ST_WR;
                sda_oe <= 1'b0;
                bitc_q <= '0;
              end
            end
          end
          asfn_pkg::ST_RD: begin
            if (scl_fall) begin
              if (bitc_q == 4'h8) begin
                st_q   <= asfn_pkg::ST_RACK;
                sda_oe <= 1'b0;
              end else begin
                sda_oe <= !sh_q[7];
                sh_q   <= {sh_q[6:0], 1'b0};
                bitc_q <= bitc_q + 1'b1;
              end
            end
          end
          asfn_pkg::ST_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_in;
            end else if (scl_fall) begin
              if (nack_q) begin
                st_q <= asfn_pkg::ST_IDLE;
              end else begin
                st_q   <= asfn_pkg::ST_RD;
                sh_q   <= {rd_byte[6:0], 1'b0};
                sda_oe <= !rd_byte[7];
                bitc_q <= 4'h1;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register pointer, local writes, forwarded writes and the main's control word
  logic rd_adv;
  // Advance as each byte ends, so the next burst byte is loaded from the new address
  assign rd_adv = scl_fall && st_q == asfn_pkg::ST_RD && bitc_q == 4'h8 && !remote_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < int'(asfn_pkg::REG_NUM); i++) begin
        regs_q[i] <= asfn_pkg::REG_RESET;
      end
      ptr_q      <= '0;
      bidx_q     <= '0;
      rem_node_q <= '0;
      rem_reg_q  <= '0;
      rem_data_q <= '0;
      rem_pend_q <= 1'b0;
      cf_word_q  <= '0;
    end else begin
      if (st_q == asfn_pkg::ST_ADDR) begin
        bidx_q <= '0;
      end
      if (frame_tick && is_main) begin
        cf_word_q  <= '{node: rem_node_q[3:0], wr: rem_pend_q, pad: 3'h0,
                        reg_addr: rem_reg_q, data: rem_data_q};
        rem_pend_q <= 1'b0;
      end
      if (cw_apply) begin
        regs_q[cw_rx.reg_addr[3:0]] <= cw_rx.data;
      end
      if (rd_adv) begin
        ptr_q <= ptr_q + 1'b1;
      end
      if (byte_wr) begin
        if (bidx_q != 2'h3) begin
          bidx_q <= bidx_q + 1'b1;
        end
        if (remote_q) begin
          if (bidx_q == 2'h0) begin
            rem_node_q <= sh_q;
          end else if (bidx_q == 2'h1) begin
            rem_reg_q <= sh_q;
          end else if (!rem_pend_q) begin
            rem_data_q <= sh_q;
            rem_pend_q <= 1'b1;
          end
        end else if (bidx_q == 2'h0) begin
          ptr_q <= sh_q[3:0];
        end else begin
          if (ptr_q != asfn_pkg::REG_STATUS) begin
            regs_q[ptr_q] <= sh_q;
          end
          ptr_q <= ptr_q + 1'b1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// >>> tb/asfn_checker.sv
// Port-level assertions for the superframe node
`timescale 1ns/1ps
`default_nettype none
module asfn_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic is_main,
  input wire logic sync_in,
  input wire logic sync_out,
  input wire logic aud_in_ready,
  input wire logic aud_out_valid,
  input wire logic a_oe,
  input wire logic b_oe,
  input wire logic b_tx,
  input wire logic scl_in,
  input wire logic sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [11:0] gap_q;
  logic        seen_q;
  logic [9:0]  oe_q;
  // Saturates so a missing frame start cannot wrap into a false match
  always_ff @(posedge clk) begin
    gap_q  <= (!resetn || aud_out_valid) ? 12'h000 : gap_q + {11'h000, gap_q != 12'hFFF};
    seen_q <= resetn && (seen_q || aud_out_valid);
  end
  always_ff @(posedge clk) begin
    oe_q <= (resetn && b_oe) ? oe_q + 10'h001 : 10'h000;
  end
  AST_MAIN_NO_UP: assert property (is_main |-> !a_oe)
    else $error("main drove the upstream link");
  AST_MAIN_NO_SYNC_OUT: assert property (is_main |-> !sync_out)
    else $error("main pulsed sync_out");
  AST_OUT_ON_SYNC: assert property (is_main && $rose(sync_in) |-> ##[1:4] aud_out_valid)
    else $error("no audio output after frame sync");
  AST_OUT_PULSE: assert property (aud_out_valid |=> !aud_out_valid [*8])
    else $error("audio output pulse too long");
  AST_FRAME_GAP: assert property (aud_out_valid && seen_q |-> gap_q == 12'hA2B)
    else $error("superframe period off");
  AST_PRE_FIRST: assert property ($rose(b_oe) |-> b_tx && sync_in)
    else $error("preamble not first after sync");
  AST_DN_LEN: assert property ($fell(b_oe) |-> oe_q inside {[10'h194:10'h19A]})
    else $error("downstream period length off");
  AST_SDA_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda changed while scl high");
  COV_OUT: cover property (aud_out_valid);
  COV_FULL: cover property (!aud_in_ready);
  COV_ACK: cover property ($rose(sda_oe));
endmodule
bind asfn_node asfn_checker asfn_checker_inst (.clk(clk), .resetn(resetn), .is_main(is_main),
  .sync_in(sync_in), .sync_out(sync_out), .aud_in_ready(aud_in_ready), .aud_out_valid(aud_out_valid),
  .a_oe(a_oe), .b_oe(b_oe), .b_tx(b_tx), .scl_in(scl_in), .sda_oe(sda_oe));
`default_nettype wire

// >>> tb/asfn_host.sv
// Host model: frame sync source and control port initiator
`timescale 1ns/1ps
`default_nettype none
module asfn_host (
  input  wire logic  clk,
  input  wire logic  sync_en,
  input  wire logic  scl,
  input  wire logic  sda,
  output logic       scl_pull,
  output logic       sda_pull,
  output logic       sync,
  output logic       res_stb,
  output logic [7:0] res_val
);
  int cnt = 0;
  logic run = 1'b0;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    sync     = 1'b0;
    res_stb  = 1'b0;
    res_val  = 8'h00;
  end
  // 2604 cycles of 8 ns give the 48 kHz frame rate
  always @(negedge clk) begin
    cnt  <= (cnt == 12'hA2B) ? 0 : cnt + 1;
    // Enable taken only at the frame boundary, so the first period is full length
    if (cnt == 12'hA2B) run <= sync_en;
    sync <= run && (cnt < 12'h040);
  end
  // Quarter bit of 79 cycles keeps the rate just under 400 kbps
  task automatic q();
    repeat (8'h4F) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    int k;
    sda_pull = !b;
    q();
    scl_pull = 1'b0;
    // Waits out clock stretching, bounded so a stuck line cannot hang
    for (k = 0; k < 4000 && !scl; k++) @(negedge clk);
    q();
    r = sda;
    q();
    scl_pull = 1'b1;
    q();
  endtask
  task automatic start();
    sda_pull = 1'b0;
    q();
    scl_pull = 1'b0;
    q();
    sda_pull = 1'b1;
    q();
    scl_pull = 1'b1;
    q();
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    q();
    scl_pull = 1'b0;
    q();
    sda_pull = 1'b0;
    q();
  endtask
  task automatic xfer(input logic [7:0] d, input logic rd, input logic last);
    logic [7:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(rd || d[i], r);
      v[i] = r;
    end
    bit_io(rd ? last : 1'b1, r);
    res_val = rd ? v : {7'h00, !r};
    res_stb = 1'b1;
    @(negedge clk);
    res_stb = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/test_asfn_node.sv
// Self-checking bench for the superframe node, main configuration
`timescale 1ns/1ps
`default_nettype none
module test_asfn_node;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        sync_en = 1'b0;
  logic        aud_in_valid = 1'b0;
  logic [15:0] aud_in_data = 16'h0000;
  logic [7:0]  cyc = 8'h00;
  logic [7:0]  d = 8'h00;
  logic [7:0]  exp_q[$];
  integer      seed = 32'hc54ea37c;
  int          n_errors = 0;
  int          n_tests = 0;
  int          ticks = 0;
  wire logic   sync, sync_out, aud_in_ready, aud_out_valid, a_oe, b_tx, b_oe;
  wire logic   scl_oe, sda_oe, scl_pull, sda_pull, res_stb;
  wire logic [7:0] res_val;
  wire logic [15:0] aud_out_data;
  wire logic   scl = !(scl_oe || scl_pull);
  wire logic   sda = !(sda_oe || sda_pull);
  // Released link idles high, so every upstream slot reads all ones
  wire logic   b_rx = b_oe ? b_tx : 1'b1;
  asfn_node asfn_node_inst (.clk(clk), .resetn(resetn), .is_main(1'b1), .last_node(1'b0), .node_id(4'h0),
    .address_strap_low(1'b0), .address_strap_high(1'b1), .sync_in(sync), .sync_out(sync_out),
    .aud_in_valid(aud_in_valid), .aud_in_ready(aud_in_ready), .aud_in_data(aud_in_data),
    .aud_out_valid(aud_out_valid), .aud_out_data(aud_out_data), .a_rx(cyc[1]), .a_tx(), .a_oe(a_oe),
    .b_rx(b_rx), .b_tx(b_tx), .b_oe(b_oe), .scl_in(scl), .scl_oe(scl_oe), .sda_in(sda), .sda_oe(sda_oe));
  asfn_host asfn_host_inst (.clk(clk), .sync_en(sync_en), .scl(scl), .sda(sda), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .sync(sync), .res_stb(res_stb), .res_val(res_val));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] want, input string m);
    n_tests++;
    if (got !== want) begin
      n_errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc   <= cyc + 8'h01;
    ticks <= ticks + 1;
    if (ticks == 90000) begin
      n_errors++;
      close_out();
    end
    if (res_stb && exp_q.size() > 0) chk(res_val, exp_q.pop_front(), "control port result");
    if (aud_out_valid) chk(aud_out_data[15:8] & aud_out_data[7:0], 8'hFF, "audio out slot");
  end
  task automatic xb(input logic [7:0] b, input logic rd, input logic last, input logic [7:0] e);
    exp_q.push_back(e);
    asfn_host_inst.xfer(b, rd, last);
  endtask
  task automatic rd2(input logic [7:0] st);
    asfn_host_inst.start();
    xb(8'h68, 1'b0, 1'b0, 8'h01);
    xb(8'h02, 1'b0, 1'b0, 8'h01);
    asfn_host_inst.start();
    xb(8'h69, 1'b0, 1'b0, 8'h01);
    xb(8'h00, 1'b1, 1'b0, d);
    xb(8'h00, 1'b1, 1'b1, st);
    asfn_host_inst.stop();
  endtask
  initial begin
    repeat (4) @(negedge clk);
    chk({1'b0, aud_out_valid, b_oe, a_oe, sda_oe, scl_oe, sync_out, aud_in_ready}, 8'h01, "reset outputs");
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    asfn_host_inst.start();
    xb(8'h6C, 1'b0, 1'b0, 8'h00);
    asfn_host_inst.stop();
    d = 8'($random(seed));
    asfn_host_inst.start();
    xb(8'h68, 1'b0, 1'b0, 8'h01);
    xb(8'h02, 1'b0, 1'b0, 8'h01);
    xb(d, 1'b0, 1'b0, 8'h01);
    asfn_host_inst.stop();
    rd2(8'h02);
    asfn_host_inst.start();
    xb(8'h6A, 1'b0, 1'b0, 8'h01);
    asfn_host_inst.stop();
    repeat (9) begin
      aud_in_valid = 1'b1;
      aud_in_data  = 16'($random(seed));
      @(negedge clk);
    end
    aud_in_valid = 1'b0;
    chk({7'h00, aud_in_ready}, 8'h00, "fifo not full after 8");
    sync_en = 1'b1;
    repeat (7812) @(negedge clk);
    chk({7'h00, aud_in_ready}, 8'h01, "fifo not drained per frame");
    rd2(8'h06);
    close_out();
  end
endmodule
`default_nettype wire
